// ===== verilog/bcrc_pkg.sv
// Shared constants and types of the byte-serial CRC unit.
package bcrc_pkg;

	// Register byte addresses within the unit's window.
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_INPUT = 8'h04;
	localparam logic [7:0] ADDR_RESULT = 8'h08;
	localparam logic [7:0] ADDR_FLIP = 8'h0C;

	// Control register field positions.
	localparam int CTRL_PTR_LSB = 0;
	localparam int CTRL_VAL_BIT = 2;
	localparam int CTRL_INIT_BIT = 3;
	localparam int CTRL_SEL_BIT = 4;

	// Generator polynomials.
	localparam logic [15:0] POLY_16 = 16'h1021;
	localparam logic [31:0] POLY_32 = 32'h04C11DB7;

	// Starting results and width masks.
	localparam logic [31:0] INIT_ZEROS = 32'h00000000;
	localparam logic [31:0] INIT_ONES = 32'hFFFFFFFF;
	localparam logic [31:0] MASK_16 = 32'h0000FFFF;

	// Values after reset.
	localparam logic [31:0] RESULT_RESET = 32'h00000000;
	localparam logic [1:0] PTR_RESET = 2'h0;
	localparam logic [7:0] FLIP_RESET = 8'h00;

	// Bit steps per input byte and input buffer geometry.
	localparam logic [3:0] BYTE_STEPS = 4'h8;
	localparam int FIFO_WIDTH = 8;
	localparam int FIFO_DEPTH = 16;

	typedef enum logic {ENG_IDLE, ENG_SHIFT} bcrc_eng_t;

endpackage

// ===== verilog/bcrc_stream_if.sv
// Valid/ready byte stream between the bus front end, buffer and engine.
`timescale 1ns/1ps
interface bcrc_stream_if #(parameter int W = 8) ();
	logic [W-1:0] data;
	logic valid;
	logic ready;
	modport source (output data, output valid, input ready);
	modport sink (input data, input valid, output ready);
endinterface // bcrc_stream_if

// ===== verilog/bcrc_fifo.sv
// Input byte buffer with parameterised width and depth.
`timescale 1ns/1ps
module bcrc_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic rstn,
	bcrc_stream_if.sink in_s,
	bcrc_stream_if.source out_s
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
	localparam logic [CW-1:0] FULL = CW'(DEPTH);

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0] wr_ptr_r, wr_ptr_nxt, rd_ptr_r, rd_ptr_nxt;
	logic [CW-1:0] count_r, count_nxt;
	logic push, pop;

	assign in_s.ready = (count_r != FULL);
	assign out_s.valid = (count_r != '0);
	assign out_s.data = mem_r[rd_ptr_r];
	assign push = in_s.valid & in_s.ready;
	assign pop = out_s.valid & out_s.ready;

	always_comb
	begin
		wr_ptr_nxt = wr_ptr_r;
		rd_ptr_nxt = rd_ptr_r;
		count_nxt = count_r;
		if (push)
			wr_ptr_nxt = (wr_ptr_r == LAST) ? '0 : wr_ptr_r + 1'b1;
		if (pop)
			rd_ptr_nxt = (rd_ptr_r == LAST) ? '0 : rd_ptr_r + 1'b1;
		if (push && !pop)
			count_nxt = count_r + 1'b1;
		else if (pop && !push)
			count_nxt = count_r - 1'b1;
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r <= '0;
		end
		else
		begin
			wr_ptr_r <= wr_ptr_nxt;
			rd_ptr_r <= rd_ptr_nxt;
			count_r <= count_nxt;
		end
	end

	// Storage has no reset; a slot is only read after it was written.
	always_ff @(posedge clk)
	begin
		if (push)
			mem_r[wr_ptr_r] <= in_s.data;
	end

endmodule // bcrc_fifo

// ===== verilog/bcrc_unit.sv
// Byte-serial CRC unit with bit-reverse register on an AHB-Lite slave.
//
// How it works
// R1: Polynomials 0x1021 and 0x04C11DB7 only.
// R2: Select bit zero picks 32-bit, one 16-bit.
// R3: Result width follows selected polynomial.
// R4: Value bit picks all-zeros or all-ones start.
// R5: Init write loads selected starting value.
// R6: Software selects polynomial, value, then initialises.
// R7: Input arrives as single bytes, one per write.
// R8: Byte XORed into result's top byte first.
// R9: Shift left, XOR polynomial if top bit was set.
// R10: Eight conditional steps per input byte.
// R11: Each input write updates result without start command.
// R12: Pointer picks result byte, advances per access.
// R13: Result holds until init, port write, input; here a control write that selects 16-bit also clears result bits 31:16.
// R14: Bit-reverse register returns written byte mirrored.
// R15: Two-bit pointer wraps at top active byte.
// R16: 16-bit mode uses low sixteen bits only.
// R17: Init bit is a one-cycle strobe.
//
// Chosen here: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
module bcrc_unit (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp
);
	import bcrc_pkg::*;

	function automatic logic [31:0] width_mask(input logic sel16);
		width_mask = sel16 ? MASK_16 : INIT_ONES; // see R3
	endfunction

	// One conditional shift-and-XOR step at the active width.
	function automatic logic [31:0] crc_step(input logic [31:0] r,
		input logic sel16);
		logic [15:0] h;
		h = r[15:0];
		if (sel16)
			crc_step = {16'h0000, h[15] ? ({h[14:0], 1'b0} ^ POLY_16)
				: {h[14:0], 1'b0}}; // see R9, R16, R1
		else
			crc_step = r[31] ? ({r[30:0], 1'b0} ^ POLY_32)
				: {r[30:0], 1'b0}; // see R9, R1, R2
	endfunction

	function automatic logic [31:0] load_byte(input logic [31:0] r,
		input logic [7:0] b, input logic sel16);
		if (sel16)
			load_byte = r ^ {16'h0000, b, 8'h00}; // see R8, R16
		else
			load_byte = r ^ {b, 24'h000000}; // see R8
	endfunction

	function automatic logic [7:0] get_byte(input logic [31:0] r,
		input logic [1:0] p);
		get_byte = r[8*p +: 8];
	endfunction

	function automatic logic [31:0] put_byte(input logic [31:0] r,
		input logic [1:0] p, input logic [7:0] b);
		logic [31:0] t;
		t = r;
		t[8*p +: 8] = b;
		put_byte = t;
	endfunction

	function automatic logic [1:0] ptr_step(input logic [1:0] p,
		input logic sel16);
		if (sel16)
			ptr_step = {1'b0, ~p[0]}; // see R15
		else
			ptr_step = p + 2'h1; // see R15
	endfunction

	function automatic logic [7:0] mirror(input logic [7:0] b);
		logic [7:0] m;
		m = '0;
		for (int i = 0; i < 8; i++)
			m[i] = b[7-i];
		mirror = m;
	endfunction

	bcrc_stream_if #(.W(FIFO_WIDTH)) to_fifo ();
	bcrc_stream_if #(.W(FIFO_WIDTH)) from_fifo ();

	bcrc_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk(hclk),
		.rstn(hresetn),
		.in_s(to_fifo),
		.out_s(from_fifo)
	);

	// Bus front end state.
	logic pend_r, pend_nxt;
	logic wr_r, wr_nxt;
	logic [7:0] addr_r, addr_nxt;
	logic hreadyout_r, hreadyout_nxt;
	logic [31:0] hrdata_r, hrdata_nxt;
	logic hresp_r;

	// Unit state.
	logic sel16_r, sel16_nxt;
	logic val_r, val_nxt;
	logic [1:0] ptr_r, ptr_nxt;
	logic [7:0] flip_r, flip_nxt;
	logic [31:0] res_r, res_nxt;
	bcrc_eng_t eng_r, eng_nxt;
	logic [3:0] cnt_r, cnt_nxt;

	logic take, quiet, can, do_acc;
	logic is_ctrl, is_input, is_result, is_flip;

	assign take = hsel & hready & htrans[1];
	assign is_ctrl = (addr_r == ADDR_CTRL);
	assign is_input = (addr_r == ADDR_INPUT);
	assign is_result = (addr_r == ADDR_RESULT);
	assign is_flip = (addr_r == ADDR_FLIP);
	// Result and control accesses wait until all buffered bytes are
	// folded in, so software always sees the result of its own writes.
	assign quiet = !from_fifo.valid && (eng_r == ENG_IDLE);
	assign can = (is_input && wr_r) ? to_fifo.ready
		: ((is_ctrl || is_result) ? quiet : 1'b1);
	assign do_acc = pend_r & can;

	assign to_fifo.valid = do_acc & is_input & wr_r;
	assign to_fifo.data = hwdata[7:0]; // see R7
	assign from_fifo.ready = (eng_r == ENG_IDLE); // see R11

	assign hreadyout = hreadyout_r;
	assign hrdata = hrdata_r;
	assign hresp = hresp_r;

	always_comb
	begin
		pend_nxt = pend_r;
		wr_nxt = wr_r;
		addr_nxt = addr_r;
		hreadyout_nxt = hreadyout_r;
		hrdata_nxt = hrdata_r;
		if (do_acc)
		begin
			pend_nxt = 1'b0;
			hreadyout_nxt = 1'b1;
			hrdata_nxt = '0;
			if (!wr_r)
			begin
				if (is_ctrl)
				begin
					hrdata_nxt[CTRL_SEL_BIT] = sel16_r;
					hrdata_nxt[CTRL_VAL_BIT] = val_r;
					hrdata_nxt[CTRL_PTR_LSB +: 2] = ptr_r;
				end
				else if (is_result)
					hrdata_nxt[7:0] = get_byte(res_r, ptr_r); // see R12
				else if (is_flip)
					hrdata_nxt[7:0] = mirror(flip_r); // see R14
			end
		end
		else if (take && hreadyout_r)
		begin
			pend_nxt = 1'b1;
			wr_nxt = hwrite;
			addr_nxt = haddr[7:0];
			hreadyout_nxt = 1'b0;
		end
	end

	always_comb
	begin
		sel16_nxt = sel16_r;
		val_nxt = val_r;
		ptr_nxt = ptr_r;
		flip_nxt = flip_r;
		res_nxt = res_r;
		eng_nxt = eng_r;
		cnt_nxt = cnt_r;
		unique case (eng_r)
			ENG_IDLE:
				if (from_fifo.valid)
				begin
					res_nxt = load_byte(res_r, from_fifo.data, sel16_r);
					eng_nxt = ENG_SHIFT;
					cnt_nxt = BYTE_STEPS; // see R10
				end
			ENG_SHIFT:
			begin
				res_nxt = crc_step(res_r, sel16_r); // see R9
				cnt_nxt = cnt_r - 4'h1;
				if (cnt_r == 4'h1)
					eng_nxt = ENG_IDLE; // see R10
			end
		endcase
		if (do_acc && is_ctrl && wr_r)
		begin
			sel16_nxt = hwdata[CTRL_SEL_BIT]; // see R2
			val_nxt = hwdata[CTRL_VAL_BIT];
			ptr_nxt = hwdata[CTRL_PTR_LSB +: 2];
			// The strobe is not stored; it uses the values written with it.
			if (hwdata[CTRL_INIT_BIT])
				res_nxt = hwdata[CTRL_VAL_BIT] ? INIT_ONES
					: INIT_ZEROS; // see R4, R5, R17
		end
		if (do_acc && is_result)
		begin
			if (wr_r)
				res_nxt = put_byte(res_r, ptr_r, hwdata[7:0]); // see R13
			ptr_nxt = ptr_step(ptr_r, sel16_r); // see R12
		end
		if (do_acc && is_flip && wr_r)
			flip_nxt = hwdata[7:0];
		res_nxt = res_nxt & width_mask(sel16_nxt); // see R3, R16
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			pend_r <= 1'b0;
			wr_r <= 1'b0;
			addr_r <= 8'h00;
			hreadyout_r <= 1'b1;
			hrdata_r <= 32'h00000000;
			hresp_r <= 1'b0;
			sel16_r <= 1'b0;
			val_r <= 1'b0;
			ptr_r <= PTR_RESET;
			flip_r <= FLIP_RESET;
			res_r <= RESULT_RESET;
			eng_r <= ENG_IDLE;
			cnt_r <= 4'h0;
		end
		else
		begin
			pend_r <= pend_nxt;
			wr_r <= wr_nxt;
			addr_r <= addr_nxt;
			hreadyout_r <= hreadyout_nxt;
			hrdata_r <= hrdata_nxt;
			hresp_r <= 1'b0;
			sel16_r <= sel16_nxt;
			val_r <= val_nxt;
			ptr_r <= ptr_nxt;
			flip_r <= flip_nxt;
			res_r <= res_nxt;
			eng_r <= eng_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence s_byte_start;
		eng_r == ENG_IDLE && from_fifo.valid;
	endsequence

	sequence s_eight_steps;
		(eng_r == ENG_SHIFT) [*8] ##1 (eng_r == ENG_IDLE);
	endsequence

	a_eight_steps: assert property ( // see R10
		s_byte_start |=> s_eight_steps)
		else $error("byte did not take exactly eight steps");

	a_poly_step_16: assert property ( // see R1
		eng_r == ENG_SHIFT && sel16_r && res_r[15] |=>
		res_r[15:0] == ({$past(res_r[14:0]), 1'b0} ^ 16'h1021))
		else $error("16-bit step wrong");

	a_poly_step_32: assert property ( // see R9
		eng_r == ENG_SHIFT && !sel16_r |=>
		res_r == ($past(res_r[31]) ? ({$past(res_r[30:0]), 1'b0}
		^ 32'h04C11DB7) : {$past(res_r[30:0]), 1'b0}))
		else $error("32-bit step wrong");

	a_width_16: assert property ( // see R3
		sel16_r |-> res_r[31:16] == 16'h0000)
		else $error("upper result bits set in 16-bit mode");

	a_init_value: assert property ( // see R5
		do_acc && is_ctrl && wr_r && hwdata[3] |=>
		res_r == (val_r ? (sel16_r ? 32'h0000FFFF : 32'hFFFFFFFF)
		: 32'h00000000))
		else $error("init did not load starting value");

	a_byte_xor: assert property ( // see R8
		s_byte_start and !sel16_r |=>
		res_r[31:24] == ($past(res_r[31:24]) ^ $past(from_fifo.data)))
		else $error("input byte not folded into top byte");

	a_auto_update: assert property ( // see R11
		do_acc && is_input && wr_r |-> ##[1:200] s_byte_start)
		else $error("written byte never processed");

	a_ptr_advance: assert property ( // see R12
		do_acc && is_result |=> ptr_r == ($past(sel16_r)
		? {1'b0, ~$past(ptr_r[0])} : $past(ptr_r) + 2'h1))
		else $error("pointer did not advance");

	a_result_hold: assert property ( // see R13
		eng_r == ENG_IDLE && !from_fifo.valid && !(do_acc && wr_r
		&& (is_ctrl || is_result)) |=> $stable(res_r))
		else $error("result changed without cause");

	a_flip_read: assert property ( // see R14
		do_acc && is_flip && !wr_r |=>
		hrdata_r[7:0] == {flip_r[0], flip_r[1], flip_r[2], flip_r[3],
		flip_r[4], flip_r[5], flip_r[6], flip_r[7]})
		else $error("bit-reverse read wrong");

	a_init_strobe: assert property ( // see R17
		do_acc && is_ctrl && !wr_r |=> hrdata_r[3] == 1'b0)
		else $error("init bit read back set");

endmodule // bcrc_unit

// ===== test/bcrc_unit_test.sv
// Self-checking bench for the byte-serial CRC unit over AHB-Lite.
`timescale 1ns/1ps
module bcrc_unit_test;
	import bcrc_pkg::*;
	logic hclk;
	logic hresetn;
	logic hsel;
	logic [31:0] haddr;
	logic [1:0] htrans;
	logic hwrite;
	logic [2:0] hsize;
	logic [31:0] hwdata;
	logic hreadyout;
	logic [31:0] hrdata;
	logic hresp;
	int fails;
	int n_compared;
	int k;
	int t;
	logic [31:0] rd;
	logic [31:0] acc;
	logic [7:0] b;
	logic [39:0] vec_b [5] = '{40'h63, 40'h8C, 40'h7D, 40'hAABBCC,
		40'h0000AABBCC};
	int vec_n [5] = '{1, 1, 1, 3, 5};
	logic [15:0] vec_o [5] = '{16'hBD35, 16'hB1F4, 16'h4ECA, 16'h6CF6,
		16'hB166};

	bcrc_unit u_bcrc_unit (
		.hclk(hclk),
		.hresetn(hresetn),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(hsize),
		.hwdata(hwdata),
		.hready(hreadyout),
		.hreadyout(hreadyout),
		.hrdata(hrdata),
		.hresp(hresp)
	);

	initial
	begin
		hclk = 1'b0;
		forever #2.5 hclk = ~hclk;
	end

	// Reference fold of one byte, written straight from the algorithm.
	function automatic logic [31:0] crc_ref(input logic [31:0] r,
		input logic [7:0] d, input logic s16);
		logic [31:0] v;
		v = r;
		if (s16)
			v[15:8] = v[15:8] ^ d;
		else
			v[31:24] = v[31:24] ^ d;
		for (int i = 0; i < 8; i++)
		begin
			if (s16)
				v = v[15] ? (({v[30:0], 1'b0} ^ {16'h0000, POLY_16}) & MASK_16)
					: ({v[30:0], 1'b0} & MASK_16);
			else
				v = v[31] ? ({v[30:0], 1'b0} ^ POLY_32) : {v[30:0], 1'b0};
		end
		return v;
	endfunction

	task automatic check(input logic [31:0] got, input logic [31:0] e,
		input string m);
		n_compared++;
		if (got !== e)
		begin
			fails++;
			$display("wrong value at %0t: %s got %h expected %h", $time, m,
				got, e);
		end
	endtask

	// One single transfer; the wait ends only when the slave answers.
	task automatic bus(input logic [7:0] a, input logic w,
		input logic [31:0] wd, output logic [31:0] q);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
		check({31'h0, hresp}, 32'h0, "response code");
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(a, 1'b1, d, q);
	endtask

	task automatic rdw(input logic [7:0] a, output logic [31:0] q);
		bus(a, 1'b0, 32'h00000000, q);
	endtask

	// Result bytes come out least significant first through the pointer.
	task automatic read_res(input int n, output logic [31:0] v);
		logic [31:0] q;
		v = 32'h00000000;
		for (int i = 0; i < n; i++)
		begin
			rdw(ADDR_RESULT, q);
			v[8*i+:8] = q[7:0];
		end
	endtask

	task automatic complete_run;
		$display("compared %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	initial
	begin
		repeat (30000) @(posedge hclk);
		fails++;
		$display("wrong value at %0t: bus wait never ended", $time);
		complete_run;
	end

	initial
	begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h00000000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h00000000;
		fails = 0;
		n_compared = 0;
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		rdw(ADDR_CTRL, rd);
		check(rd, 32'h00000000, "control after reset");
		read_res(4, rd);
		check(rd, RESULT_RESET, "result after reset");
		$display("test reset done");
		for (t = 0; t < 5; t++)
		begin
			wr(ADDR_CTRL, 32'h0000001C);
			acc = 32'h00000000;
			for (k = 0; k < vec_n[t]; k++)
			begin
				b = vec_b[t][8*(vec_n[t]-1-k)+:8];
				wr(ADDR_INPUT, {24'h000000, b});
			end
			read_res(2, rd);
			check(rd, {16'h0000, vec_o[t]}, "crc16 vector");
			rdw(ADDR_RESULT, rd);
			check({24'h0, rd[7:0]}, {24'h0, vec_o[t][7:0]}, "wrap16");
		end
		$display("test crc16 vectors done");
		// Thirty-two bytes back to back fill the 16-byte buffer, so the
		// bus has to stall on input writes until the engine frees a slot.
		wr(ADDR_CTRL, 32'h0000000C);
		acc = INIT_ONES;
		for (k = 0; k < 32; k++)
		begin
			b = 8'(k * 8'h1D) ^ 8'h5A;
			wr(ADDR_INPUT, {24'hFFFFFF, b});
			acc = crc_ref(acc, b, 1'b0);
		end
		read_res(4, rd);
		check(rd, acc, "crc32 stream");
		rdw(ADDR_RESULT, rd);
		check({24'h0, rd[7:0]}, {24'h0, acc[7:0]}, "wrap32");
		$display("test crc32 stream done");
		wr(ADDR_CTRL, 32'h00000008);
		read_res(4, rd);
		check(rd, INIT_ZEROS, "init zeros");
		wr(ADDR_CTRL, 32'h0000001C);
		read_res(2, rd);
		check(rd, INIT_ONES & MASK_16, "init ones 16");
		rdw(ADDR_CTRL, rd);
		check(rd, 32'h00000014, "strobe clear, pointer back");
		$display("test init done");
		wr(ADDR_CTRL, 32'h0000000C);
		wr(ADDR_CTRL, 32'h00000002);
		wr(ADDR_RESULT, 32'h000000A5);
		rdw(ADDR_CTRL, rd);
		check(rd, 32'h00000003, "pointer after port write");
		wr(ADDR_CTRL, 32'h00000000);
		read_res(4, rd);
		check(rd, 32'hFFA5FFFF, "port write byte");
		read_res(4, rd);
		check(rd, 32'hFFA5FFFF, "result held");
		$display("test result port done");
		for (t = 0; t < 4; t++)
		begin
			b = 8'hC0 ^ 8'(t * 8'h35);
			wr(ADDR_FLIP, {24'h000000, b});
			rdw(ADDR_FLIP, rd);
			check({24'h0, rd[7:0]}, {24'h0, b[0], b[1], b[2], b[3], b[4],
				b[5], b[6], b[7]}, "mirror");
		end
		wr(ADDR_FLIP, 32'h000000C0);
		rdw(ADDR_FLIP, rd);
		check({24'h0, rd[7:0]}, 32'h00000003, "mirror C0");
		$display("test bit reverse done");
		wr(8'h10, 32'hDEADBEEF);
		rdw(8'h10, rd);
		check(rd, 32'h00000000, "unmapped read");
		rdw(ADDR_INPUT, rd);
		check(rd, 32'h00000000, "input read");
		read_res(4, rd);
		check(rd, 32'hFFA5FFFF, "result after stray access");
		$display("test unmapped done");
		complete_run;
	end
endmodule // bcrc_unit_test
